/* File: pkg/cfst_map.vh */
// register map, field positions and constants of the camera feature/status/time-base block
`ifndef CFST_MAP_VH
`define CFST_MAP_VH

// byte addresses on the register bus
`define CFST_ADDR_FEAT1 32'hf1000040
`define CFST_ADDR_FEAT2 32'hf1000044
`define CFST_ADDR_FEAT3 32'hf1000048
`define CFST_ADDR_FEAT4 32'hf100004c
`define CFST_ADDR_STHDR 32'hf1000100
`define CFST_ADDR_STFLG 32'hf1000104
`define CFST_ADDR_SIZE 32'hf1000200
`define CFST_ADDR_TBASE 32'hf1000208

// feature presence words (msb-first numbering: feature n sits at verilog bit 31-n)
`define CFST_FEAT1_VAL 32'hc0000000
`define CFST_FEAT2_VAL 32'h00000000
`define CFST_FEAT3_VAL 32'h80000000
`define CFST_FEAT4_VAL 32'h00000000

// field positions, verilog numbering
`define CFST_PRESENT_BIT 31
`define CFST_IDLE_BIT 0
`define CFST_ISO_BIT 3
`define CFST_ARMED_BIT 16
`define CFST_HDR_ID_MSB 7
`define CFST_HDR_ID_LSB 0
`define CFST_COLS_MSB 31
`define CFST_COLS_LSB 16
`define CFST_ROWS_MSB 15
`define CFST_ROWS_LSB 0
`define CFST_OFS_MSB 23
`define CFST_OFS_LSB 12
`define CFST_TBID_MSB 3
`define CFST_TBID_LSB 0

// time-base codes and periods in microseconds
`define CFST_TBID_MAX 4'h9
`define CFST_TBID_RESET 4'h4
`define CFST_TB0_US 10'h001
`define CFST_TB1_US 10'h002
`define CFST_TB2_US 10'h005
`define CFST_TB3_US 10'h00a
`define CFST_TB4_US 10'h014
`define CFST_TB5_US 10'h032
`define CFST_TB6_US 10'h064
`define CFST_TB7_US 10'h0c8
`define CFST_TB8_US 10'h1f4
`define CFST_TB9_US 10'h3e8
`define CFST_SHUT_MIN 12'h001

// status poll spacing
`define CFST_POLL_GAP_MS 5
`define CFST_CLK_KHZ 200000
`define CFST_GAP_W 24

`endif

/* File: rtl/cfst_regs.v */
// register bank: feature presence, camera status, sensor size and exposure time base
//
// Summary of operation
// - four presence words flag present features
// - absent feature space answers with bus error
// - idle flag when not capturing/sending; iso flag
// - armed flag while external trigger configured
// - status read within 5 ms of the last one stalled
// - status flags live, short pulses may be missed
// - presence bit set in the status header and time-base words only
// - read-only size word: columns, rows
// - size matches largest partial-scan image
// - shutter count accepted only 1 to 4095
// - integration time = shutter times time base
// - time-base code 0-9 selects the period
// - reset time base is 20 us
// - base changed when idle, applied on shutter write
// - fixed exposure offset reported, added to exposure
// - absolute-value control block reported absent
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "cfst_map.vh"

module cfst_regs #(
	parameter [`CFST_GAP_W-1:0] POLL_GAP_CYC = `CFST_POLL_GAP_MS * `CFST_CLK_KHZ,
	parameter [15:0] SENSOR_COLUMNS = 16'h0280,
	parameter [15:0] SENSOR_ROWS = 16'h01e0,
	parameter [11:0] EXPOSURE_FIXED_OFFSET = 12'h000,
	// implementation id, arbitrary value
	parameter [7:0] STATUS_IMPL_ID = 8'h5a
) (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// camera state, same clock
	input wire camCapturing,
	input wire camSending,
	input wire extTrigConfigured,
	// shutter register write from the control core
	input wire shutterWrStb,
	input wire [11:0] shutterVal,
	// exposure results and idle flag
	output reg [21:0] integrationUs,
	output reg [22:0] exposureUs,
	output reg [3:0] activeUnitCode,
	output reg idleFlag
);

////////////////////////////////////////////////////////////////////////////////
// state

reg [3:0] selUnitCode_r;
reg [3:0] selUnitCode_nxt;
reg [`CFST_GAP_W-1:0] gapCnt_r;
reg [11:0] shutter_r;
reg isoFlag_r;
reg armedFlag_r;
reg [9:0] unitUs;
reg [21:0] intProd;
reg [31:0] rdMux;
reg decHit;
reg isStatus;

wire accessPh;
wire doneXfer;
wire wrDone;
wire statusDone;
wire idleNow;

assign accessPh = psel & penable;
assign doneXfer = accessPh & pready;
assign wrDone = doneXfer & pwrite & ~pslverr;
assign idleNow = ~camCapturing & ~camSending;
assign statusDone = doneXfer & ~pwrite & isStatus;

////////////////////////////////////////////////////////////////////////////////
// address decode and read data (bit 0 of the documents is verilog bit 31)

always @* begin
	rdMux = 32'h00000000;
	decHit = 1'b1;
	isStatus = 1'b0;
	case (paddr)
	`CFST_ADDR_FEAT1: begin
		rdMux = `CFST_FEAT1_VAL;
	end
	`CFST_ADDR_FEAT2: begin
		rdMux = `CFST_FEAT2_VAL;
	end
	`CFST_ADDR_FEAT3: begin
		rdMux = `CFST_FEAT3_VAL;
	end
	`CFST_ADDR_FEAT4: begin
		rdMux = `CFST_FEAT4_VAL;
	end
	`CFST_ADDR_STHDR: begin
		isStatus = 1'b1;
		rdMux[`CFST_PRESENT_BIT] = 1'b1;
		rdMux[`CFST_HDR_ID_MSB:`CFST_HDR_ID_LSB] = STATUS_IMPL_ID;
	end
	`CFST_ADDR_STFLG: begin
		isStatus = 1'b1;
		rdMux[`CFST_IDLE_BIT] = idleFlag;
		rdMux[`CFST_ISO_BIT] = isoFlag_r;
		rdMux[`CFST_ARMED_BIT] = armedFlag_r;
	end
	`CFST_ADDR_SIZE: begin
		rdMux[`CFST_COLS_MSB:`CFST_COLS_LSB] = SENSOR_COLUMNS;
		rdMux[`CFST_ROWS_MSB:`CFST_ROWS_LSB] = SENSOR_ROWS;
	end
	`CFST_ADDR_TBASE: begin
		rdMux[`CFST_PRESENT_BIT] = 1'b1;
		rdMux[`CFST_OFS_MSB:`CFST_OFS_LSB] = EXPOSURE_FIXED_OFFSET;
		rdMux[`CFST_TBID_MSB:`CFST_TBID_LSB] = selUnitCode_r;
	end
	default: begin
		decHit = 1'b0;
	end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// apb handshake; a status read waits out the poll gap before answering

always @(posedge ref_clk) begin
	if (rst) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
	end else if (accessPh & ~pready & ~(isStatus & ~pwrite & (gapCnt_r != 0))) begin
		pready <= 1'b1;
		pslverr <= ~decHit;
		prdata <= pwrite ? 32'h00000000 : rdMux;
	end else begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
	end
end

// gap restarts on every completed status read
always @(posedge ref_clk) begin
	if (rst) begin
		gapCnt_r <= {`CFST_GAP_W{1'b0}};
	end else if (statusDone) begin
		gapCnt_r <= POLL_GAP_CYC;
	end else if (gapCnt_r != 0) begin
		gapCnt_r <= gapCnt_r - 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// live status flags, one cycle of sampling, no stretching

always @(posedge ref_clk) begin
	if (rst) begin
		idleFlag <= 1'b1;
		isoFlag_r <= 1'b0;
		armedFlag_r <= 1'b0;
	end else begin
		idleFlag <= idleNow;
		isoFlag_r <= camSending;
		armedFlag_r <= extTrigConfigured;
	end
end

////////////////////////////////////////////////////////////////////////////////
// time-base selection; a busy camera keeps its old selection

always @* begin
	selUnitCode_nxt = selUnitCode_r;
	if (wrDone && paddr == `CFST_ADDR_TBASE && idleFlag
		&& pwdata[`CFST_TBID_MSB:`CFST_TBID_LSB] <= `CFST_TBID_MAX) begin
		selUnitCode_nxt = pwdata[`CFST_TBID_MSB:`CFST_TBID_LSB];
	end
end

// selection takes effect only with the next accepted shutter count
always @(posedge ref_clk) begin
	if (rst) begin
		selUnitCode_r <= `CFST_TBID_RESET;
		activeUnitCode <= `CFST_TBID_RESET;
		shutter_r <= `CFST_SHUT_MIN;
	end else begin
		selUnitCode_r <= selUnitCode_nxt;
		if (shutterWrStb && shutterVal >= `CFST_SHUT_MIN) begin
			shutter_r <= shutterVal;
			activeUnitCode <= selUnitCode_r;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// exposure arithmetic

always @* begin
	case (activeUnitCode)
	4'h0: unitUs = `CFST_TB0_US;
	4'h1: unitUs = `CFST_TB1_US;
	4'h2: unitUs = `CFST_TB2_US;
	4'h3: unitUs = `CFST_TB3_US;
	4'h4: unitUs = `CFST_TB4_US;
	4'h5: unitUs = `CFST_TB5_US;
	4'h6: unitUs = `CFST_TB6_US;
	4'h7: unitUs = `CFST_TB7_US;
	4'h8: unitUs = `CFST_TB8_US;
	4'h9: unitUs = `CFST_TB9_US;
	default: unitUs = `CFST_TB4_US;
	endcase
	intProd = {10'h000, shutter_r} * {12'h000, unitUs};
end

// results lag the shutter write by two cycles
always @(posedge ref_clk) begin
	if (rst) begin
		integrationUs <= 22'h000000;
		exposureUs <= 23'h000000;
	end else begin
		integrationUs <= intProd;
		exposureUs <= {1'b0, intProd} + {11'h000, EXPOSURE_FIXED_OFFSET};
	end
end

endmodule

/* File: testbench/cfst_regs_chk.sv */
// assertion checker for the camera feature/status/time-base register bank
`timescale 1ns/1ps
`include "cfst_map.vh"
module cfst_regs_chk #(
	parameter [`CFST_GAP_W-1:0] POLL_GAP_CYC = 20,
	parameter [11:0] EXPOSURE_FIXED_OFFSET = 12'h000
) (
	// clock, reset and apb
	input wire ref_clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// camera side
	input wire camCapturing,
	input wire camSending,
	input wire extTrigConfigured,
	input wire shutterWrStb,
	input wire [11:0] shutterVal,
	input wire [21:0] integrationUs,
	input wire [22:0] exposureUs,
	input wire [3:0] activeUnitCode,
	input wire idleFlag
);
	localparam int PER [10] = '{1, 2, 5, 10, 20, 50, 100, 200, 500, 1000};
	wire isStat = paddr == `CFST_ADDR_STHDR || paddr == `CFST_ADDR_STFLG;
	wire mapped = isStat || paddr inside {`CFST_ADDR_FEAT1, `CFST_ADDR_FEAT2,
		`CFST_ADDR_FEAT3, `CFST_ADDR_FEAT4, `CFST_ADDR_SIZE, `CFST_ADDR_TBASE};
	int sinceStat;
	////////////////////////////////////////////////////////////////////////////////
	// saturating age of the last status answer; zero means none since reset
	always @(posedge ref_clk) begin
		if (rst)
			sinceStat <= 0;
		else if (pready && isStat)
			sinceStat <= 1;
		else if (sinceStat != 0 && sinceStat < 100000)
			sinceStat <= sinceStat + 1;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence validShot;
		shutterWrStb && shutterVal != 12'h000;
	endsequence
	a_idle_tracks: assert property (1'b1 |=> idleFlag == !$past(camCapturing || camSending))
		else $error("idle flag does not follow activity");
	a_integ_product: assert property (validShot |=> ##1
		integrationUs == $past(shutterVal, 2) * PER[activeUnitCode])
		else $error("integration time is not shutter times base");
	a_zero_ignored: assert property (shutterWrStb && shutterVal == 12'h000 |=> ##1
		$stable(integrationUs))
		else $error("zero shutter count was applied");
	a_unit_hold: assert property (!shutterWrStb |=> $stable(activeUnitCode))
		else $error("time base changed without shutter write");
	a_offset_added: assert property (!$past(rst) |->
		exposureUs == integrationUs + EXPOSURE_FIXED_OFFSET)
		else $error("exposure lacks the fixed offset");
	a_status_gap: assert property (pready && isStat |->
		sinceStat == 0 || sinceStat >= POLL_GAP_CYC)
		else $error("status answered inside the poll gap");
	a_err_unmapped: assert property (pready |-> pslverr == !mapped)
		else $error("error response does not match decode");
	a_ready_next: assert property (psel && penable && !pready && !isStat |=> pready)
		else $error("register answer late");
endmodule
bind cfst_regs cfst_regs_chk #(.POLL_GAP_CYC(POLL_GAP_CYC),
	.EXPOSURE_FIXED_OFFSET(EXPOSURE_FIXED_OFFSET)) chk (.*);

/* File: testbench/cfst_regs_tb.sv */
// self-checking bench for the camera feature/status/time-base register bank
`timescale 1ns/1ps
`include "cfst_map.vh"
module cfst_regs_tb;
	localparam [11:0] OFS = 12'h01b;
	logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, shutterWrStb = 0;
	logic camCapturing = 0, camSending = 0, extTrigConfigured = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, q;
	logic [11:0] shutterVal = 0;
	logic pready, pslverr, e, idleFlag;
	logic [21:0] integrationUs;
	logic [22:0] exposureUs;
	logic [3:0] activeUnitCode;
	int bad_count = 0, checks = 0, per[10] = '{1, 2, 5, 10, 20, 50, 100, 200, 500, 1000};
	longint t;
	// short poll gap keeps the stalled status reads brief
	cfst_regs #(.POLL_GAP_CYC(24'd20), .SENSOR_COLUMNS(16'h0500), .SENSOR_ROWS(16'h0400),
		.EXPOSURE_FIXED_OFFSET(OFS), .STATUS_IMPL_ID(8'h3c)) uut (.*);
	initial forever #2.5 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, x);
		checks++;
		if (s !== x) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, s, x);
		end
	endtask
	task apb(input logic w, input logic [31:0] a, d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [31:0] a, x, input logic xe);
		apb(1'b0, a, 32'h0);
		chk(q, x);
		chk(e, xe);
	endtask
	task shut(input logic [11:0] v);
		@(posedge ref_clk);
		shutterWrStb <= 1'b1;
		shutterVal <= v;
		@(posedge ref_clk);
		shutterWrStb <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask
	task test_done;
		if (bad_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		test_done;
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk(integrationUs, 32'd20);
		rd(`CFST_ADDR_TBASE, {8'h80, OFS, 12'h004}, 1'b0);
		rd(`CFST_ADDR_FEAT1, `CFST_FEAT1_VAL, 1'b0);
		rd(`CFST_ADDR_FEAT2, `CFST_FEAT2_VAL, 1'b0);
		rd(`CFST_ADDR_FEAT3, `CFST_FEAT3_VAL, 1'b0);
		rd(`CFST_ADDR_FEAT4, `CFST_FEAT4_VAL, 1'b0);
		apb(1'b0, `CFST_ADDR_FEAT3, 32'h0);
		chk(q & 32'hfe000000, 32'h80000000);
		rd(`CFST_ADDR_STHDR, 32'h8000003c, 1'b0);
		t = $time;
		apb(1'b1, `CFST_ADDR_SIZE, 32'h0);
		rd(`CFST_ADDR_SIZE, 32'h05000400, 1'b0);
		rd(32'hf1000050, 32'h0, 1'b1);
		camSending <= 1'b1;
		extTrigConfigured <= 1'b1;
		rd(`CFST_ADDR_STFLG, 32'h00010008, 1'b0);
		chk(($time - t) >= 100, 1'b1);
		camSending <= 1'b0;
		extTrigConfigured <= 1'b0;
		rd(`CFST_ADDR_STFLG, 32'h00000001, 1'b0);
		repeat (25) @(posedge ref_clk);
		t = $time;
		apb(1'b0, `CFST_ADDR_STFLG, 32'h0);
		chk(q & 32'h00010009, 32'h00000001);
		chk(($time - t) < 50, 1'b1);
		for (int i = 0; i < 10; i++) begin
			apb(1'b1, `CFST_ADDR_TBASE, i);
			chk(activeUnitCode, i ? i - 1 : 4);
			rd(`CFST_ADDR_TBASE, {8'h80, OFS, 8'h00, 4'(i)}, 1'b0);
			shut(12'hfff);
			chk(integrationUs, 4095 * per[i]);
			chk(exposureUs, 4095 * per[i] + OFS);
		end
		shut(12'h000);
		chk(integrationUs, 32'd4095000);
		apb(1'b1, `CFST_ADDR_TBASE, 32'hb);
		rd(`CFST_ADDR_TBASE, {8'h80, OFS, 12'h009}, 1'b0);
		camCapturing <= 1'b1;
		apb(1'b1, `CFST_ADDR_TBASE, 32'h0);
		rd(`CFST_ADDR_TBASE, {8'h80, OFS, 12'h009}, 1'b0);
		camCapturing <= 1'b0;
		test_done;
	end
endmodule
